//--- hdl/ais_cfg.svh
// Constants for the analog input scaling block: object indices, entry numbers,
// field widths, preset values and divider step count.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH

// Field widths
`define AIS_ADC_W 10
`define AIS_SET_W 16
`define AIS_SUM_W 18
`define AIS_PROD_W 34
`define AIS_VAL_W 32
`define AIS_OD_W 32

// Object indices
`define AIS_IDX_VALUE 16'h3320
`define AIS_IDX_OFFSET 16'h3321
`define AIS_IDX_MULT 16'h3322
`define AIS_IDX_DIV 16'h3323

// Entry numbers within each object
`define AIS_SUB_COUNT 8'h00
`define AIS_SUB_FIRST 8'h01
`define AIS_SUB_SECOND 8'h02

// Preset values
`define AIS_COUNT_RESET 8'h02
`define AIS_OFFSET_RESET 16'h0000
`define AIS_MULT_RESET 16'h0001
`define AIS_DIV_RESET 16'h0001
`define AIS_VALUE_RESET 32'h0000_0000

// One quotient bit per step
`define AIS_DIV_STEPS 6'h22

`endif

//--- hdl/ais_div.sv
// Sequential signed divider, one quotient bit per cycle, truncating toward zero.
// Assumes start is a one-cycle pulse given only while busy is low and divisor is nonzero.
`include "ais_cfg.svh"
`default_nettype none

module ais_div (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Request
    input wire logic div_start,
    input wire logic [`AIS_PROD_W-1:0] div_dividend,
    input wire logic [`AIS_SET_W-1:0] div_divisor,
    // Result
    output logic div_busy,
    output logic div_done,
    output logic [`AIS_PROD_W-1:0] div_quo
);

    ais_pkg::ais_div_state_t s_reg;
    ais_pkg::ais_div_state_t s_next;

    function automatic logic [`AIS_PROD_W-1:0] mag(input logic [`AIS_PROD_W-1:0] v);
        mag = v[`AIS_PROD_W-1] ? -v : v;
    endfunction

    logic [`AIS_PROD_W-1:0] dsr_ext;
    logic [`AIS_PROD_W-1:0] dsr_mag;
    logic [`AIS_SET_W:0] trial;
    logic [`AIS_PROD_W-1:0] shifted;

    assign dsr_ext = {{(`AIS_PROD_W-`AIS_SET_W){div_divisor[`AIS_SET_W-1]}}, div_divisor};
    assign dsr_mag = mag(dsr_ext);

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        trial = {s_reg.rem, s_reg.quo[`AIS_PROD_W-1]};
        shifted = {s_reg.quo[`AIS_PROD_W-2:0], 1'b0};
        if (!s_reg.busy) begin
            if (div_start) begin
                s_next.busy = 1'b1;
                s_next.cnt = `AIS_DIV_STEPS;
                s_next.rem = '0;
                s_next.quo = mag(div_dividend);
                s_next.dmag = dsr_mag[`AIS_SET_W:0];
                // Divide magnitudes and fix the sign after: truncates toward zero
                s_next.neg = div_dividend[`AIS_PROD_W-1] ^ div_divisor[`AIS_SET_W-1];
            end
        end else begin
            if (trial >= s_reg.dmag) begin
                // Remainder stays below the divisor magnitude, so 16 bits always hold it
                s_next.rem = 16'(trial - s_reg.dmag);
                shifted[0] = 1'b1;
            end else begin
                s_next.rem = trial[`AIS_SET_W-1:0];
            end
            s_next.quo = shifted;
            s_next.cnt = s_reg.cnt - 6'h01;
            if (s_reg.cnt == 6'h01) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.quo = s_reg.neg ? -shifted : shifted;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign div_busy = s_reg.busy;
    assign div_done = s_reg.done;
    assign div_quo = s_reg.quo;

endmodule

`default_nettype wire

//--- hdl/ais_mul.sv
// Registered signed multiply of the offset-adjusted reading by the multiplier.
// Assumes operands stay stable for one cycle before the product is used.
`include "ais_cfg.svh"
`default_nettype none

module ais_mul (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Operands
    input wire logic [`AIS_SUM_W-1:0] mul_a,
    input wire logic [`AIS_SET_W-1:0] mul_b,
    // Product
    output logic [`AIS_PROD_W-1:0] mul_prod
);

    ais_pkg::ais_mul_state_t s_reg;
    ais_pkg::ais_mul_state_t s_next;

    always_comb begin
        s_next = s_reg;
        // Product is as wide as both operands together, so it never overflows
        s_next.prod = $signed(mul_a) * $signed(mul_b);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign mul_prod = s_reg.prod;

endmodule

`default_nettype wire

//--- hdl/ais_pkg.sv
// Types shared by the analog input scaling modules.
// Assumes ais_cfg.svh is on the include path.
`include "ais_cfg.svh"
`default_nettype none

package ais_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_DIV_GO, ST_DIV_WAIT} ais_seq_t;

    typedef struct packed {
        logic [1:0] pend;
        logic [1:0][`AIS_ADC_W-1:0] raw;
        logic [1:0][`AIS_SET_W-1:0] offset;
        logic [1:0][`AIS_SET_W-1:0] mult;
        logic [1:0][`AIS_SET_W-1:0] div;
        logic [1:0][`AIS_VAL_W-1:0] value;
        ais_seq_t seq;
        logic ch;
        logic [`AIS_SUM_W-1:0] sum;
        logic [`AIS_SET_W-1:0] mul_snap;
        logic [`AIS_SET_W-1:0] div_snap;
        logic div_start;
        logic busy;
        logic od_ack;
        logic od_abort;
        logic [`AIS_OD_W-1:0] od_rdata;
    } ais_state_t;

    typedef struct packed {
        logic [`AIS_PROD_W-1:0] prod;
    } ais_mul_state_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic neg;
        logic [`AIS_SET_W:0] dmag;
        logic [`AIS_SET_W-1:0] rem;
        logic [`AIS_PROD_W-1:0] quo;
    } ais_div_state_t;

endpackage

`default_nettype wire

//--- hdl/ais_top.sv
// Analog input scaling: offset, multiply and divide of raw converter readings,
// with object-dictionary entries for the settings and the scaled results.
// Assumes converter samples and dictionary requests come from logic on sys_clk.
//
// How it works
// - Each input's signed offset is added to its raw reading before scaling.
// - The sum is multiplied by the multiplier and, for a nonzero divisor, divided by the divisor and stored.
// - With preset offset, multiplier and divisor the result equals the raw count.
// - Entry zero of each object reads a fixed input count of 2, read only.
// - Each scaled value is a read-only signed 32-bit entry, zero after reset.
// - Each offset is a read/write signed 16-bit entry, zero after reset.
// - Each multiplier is a read/write signed 16-bit entry, one after reset.
// - Second input entries work only on variants that have a second input.
// - Each divisor is a read/write signed 16-bit entry, one after reset.
`include "ais_cfg.svh"
`default_nettype none

module ais_top #(
    parameter bit SECOND_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Converter samples
    input wire logic [`AIS_ADC_W-1:0] adc_raw_first,
    input wire logic [`AIS_ADC_W-1:0] adc_raw_second,
    input wire logic adc_valid_first,
    input wire logic adc_valid_second,
    // Object dictionary access
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic [`AIS_OD_W-1:0] od_wdata,
    output logic od_ack,
    output logic od_abort,
    output logic [`AIS_OD_W-1:0] od_rdata,
    // Scaled results
    output logic [`AIS_VAL_W-1:0] value_first,
    output logic [`AIS_VAL_W-1:0] value_second,
    output logic scale_busy
);

    ais_pkg::ais_state_t s_reg;
    ais_pkg::ais_state_t s_next;

    logic [`AIS_PROD_W-1:0] mul_prod;
    logic div_busy;
    logic div_done;
    logic [`AIS_PROD_W-1:0] div_quo;

    // Offset-adjusted reading; 18 bits hold any 10-bit count plus any 16-bit offset
    function automatic logic [`AIS_SUM_W-1:0] add_offset(
        input logic [`AIS_ADC_W-1:0] raw,
        input logic [`AIS_SET_W-1:0] off
    );
        add_offset = {8'h00, raw} + {{2{off[`AIS_SET_W-1]}}, off};
    endfunction

    ais_mul u_mul (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mul_a(s_reg.sum),
        .mul_b(s_reg.mul_snap),
        .mul_prod(mul_prod)
    );

    ais_div u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .div_start(s_reg.div_start),
        .div_dividend(mul_prod),
        .div_divisor(s_reg.div_snap),
        .div_busy(div_busy),
        .div_done(div_done),
        .div_quo(div_quo)
    );

    logic [1:0] smp_set;
    logic [1:0] smp_clr;
    logic pick;
    logic od_ch;
    logic od_ch_ok;

    always_comb begin
        s_next = s_reg;
        s_next.od_ack = 1'b0;
        s_next.od_abort = 1'b0;
        s_next.div_start = 1'b0;
        smp_clr = 2'b00;
        pick = 1'b0;

        // A missing second input never raises a sample
        smp_set = {adc_valid_second & SECOND_PRESENT, adc_valid_first};
        if (smp_set[0]) begin
            s_next.raw[0] = adc_raw_first;
        end
        if (smp_set[1]) begin
            s_next.raw[1] = adc_raw_second;
        end

        // Scaling sequence; settings are snapshotted so a write mid-sequence is safe
        case (s_reg.seq)
            ais_pkg::ST_IDLE: begin
                if (s_reg.pend != 2'b00) begin
                    pick = !s_reg.pend[0];
                    smp_clr[pick] = 1'b1;
                    s_next.ch = pick;
                    s_next.sum = add_offset(s_reg.raw[pick], s_reg.offset[pick]);
                    s_next.mul_snap = s_reg.mult[pick];
                    s_next.div_snap = s_reg.div[pick];
                    s_next.seq = ais_pkg::ST_MUL;
                end
            end
            ais_pkg::ST_MUL: begin
                s_next.seq = ais_pkg::ST_DIV_GO;
            end
            ais_pkg::ST_DIV_GO: begin
                if (s_reg.div_snap == 16'h0000) begin
                    // Dividing by zero has no answer; keep what was reported
                    s_next.seq = ais_pkg::ST_IDLE;
                end else begin
                    s_next.div_start = 1'b1;
                    s_next.seq = ais_pkg::ST_DIV_WAIT;
                end
            end
            ais_pkg::ST_DIV_WAIT: begin
                if (div_done) begin
                    // Result always fits 32 bits since the divisor magnitude is at least one
                    s_next.value[s_reg.ch] = div_quo[`AIS_VAL_W-1:0];
                    s_next.seq = ais_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next.seq = ais_pkg::ST_IDLE;
            end
        endcase

        // A sample arriving as its flag is consumed stays pending
        s_next.pend = (s_reg.pend & ~smp_clr) | smp_set;

        // Registered so the busy pin comes straight from a flop, not from a decode
        s_next.busy = (s_next.seq != ais_pkg::ST_IDLE);

        // Dictionary access, answered one cycle after the request
        od_ch = (od_subindex == `AIS_SUB_SECOND);
        od_ch_ok = (od_subindex == `AIS_SUB_FIRST) || (od_ch && SECOND_PRESENT);
        if (od_req) begin
            s_next.od_abort = 1'b1;
            case (od_index)
                `AIS_IDX_VALUE, `AIS_IDX_OFFSET, `AIS_IDX_MULT, `AIS_IDX_DIV: begin
                    if (od_subindex == `AIS_SUB_COUNT) begin
                        if (!od_write) begin
                            s_next.od_abort = 1'b0;
                            s_next.od_ack = 1'b1;
                            s_next.od_rdata = {24'h000000, `AIS_COUNT_RESET};
                        end
                    end else if (od_ch_ok) begin
                        if (!od_write) begin
                            s_next.od_abort = 1'b0;
                            s_next.od_ack = 1'b1;
                            case (od_index)
                                `AIS_IDX_VALUE: s_next.od_rdata = s_reg.value[od_ch];
                                `AIS_IDX_OFFSET: s_next.od_rdata = {16'h0000, s_reg.offset[od_ch]};
                                `AIS_IDX_MULT: s_next.od_rdata = {16'h0000, s_reg.mult[od_ch]};
                                default: s_next.od_rdata = {16'h0000, s_reg.div[od_ch]};
                            endcase
                        end else if (od_index != `AIS_IDX_VALUE) begin
                            // The scaled value itself is read only and refuses writes
                            s_next.od_abort = 1'b0;
                            s_next.od_ack = 1'b1;
                            case (od_index)
                                `AIS_IDX_OFFSET: s_next.offset[od_ch] = od_wdata[`AIS_SET_W-1:0];
                                `AIS_IDX_MULT: s_next.mult[od_ch] = od_wdata[`AIS_SET_W-1:0];
                                default: s_next.div[od_ch] = od_wdata[`AIS_SET_W-1:0];
                            endcase
                        end
                    end
                end
                default: begin
                    s_next.od_abort = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.seq <= ais_pkg::ST_IDLE;
            s_reg.offset <= {`AIS_OFFSET_RESET, `AIS_OFFSET_RESET};
            s_reg.mult <= {`AIS_MULT_RESET, `AIS_MULT_RESET};
            s_reg.div <= {`AIS_DIV_RESET, `AIS_DIV_RESET};
            s_reg.value <= {`AIS_VALUE_RESET, `AIS_VALUE_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    assign od_ack = s_reg.od_ack;
    assign od_abort = s_reg.od_abort;
    assign od_rdata = s_reg.od_rdata;
    assign value_first = s_reg.value[0];
    assign value_second = s_reg.value[1];
    assign scale_busy = s_reg.busy;

endmodule

`default_nettype wire

//--- tb/ais_adc_model.sv
// Converter stand-in giving one-cycle sample strobes with a count.
// Assumes the bench calls convert from procedural code between edges.
`include "ais_cfg.svh"
`default_nettype none

module ais_adc_model (
    // Clock
    input wire logic sys_clk,
    // Samples
    output logic [`AIS_ADC_W-1:0] adc_raw_first,
    output logic [`AIS_ADC_W-1:0] adc_raw_second,
    output logic adc_valid_first,
    output logic adc_valid_second
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] go = 2'b00;
    logic [`AIS_ADC_W-1:0] hold [2];
    initial begin
        adc_raw_first = '0;
        adc_raw_second = '0;
        adc_valid_first = 1'b0;
        adc_valid_second = 1'b0;
    end
    task automatic convert(input bit ch, input logic [`AIS_ADC_W-1:0] r);
        @(negedge sys_clk);
        hold[ch] = r;
        go[ch] = 1'b1;
    endtask
    // The count is not held between strobes, so it flips every cycle
    always @(posedge sys_clk) begin
        adc_valid_first <= go[0];
        adc_valid_second <= go[1];
        adc_raw_first <= go[0] ? hold[0] : ~adc_raw_first;
        adc_raw_second <= go[1] ? hold[1] : ~adc_raw_second;
        go = 2'b00;
    end
endmodule

`default_nettype wire

//--- tb/ais_top_assertions.sv
// Port checks for the analog input scaling top.
// Assumes one clock domain; bound onto every ais_top instance.
`include "ais_cfg.svh"
`default_nettype none

module ais_top_assertions #(
    parameter bit SECOND_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Samples
    input wire logic adc_valid_first,
    // Dictionary
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic od_ack,
    input wire logic od_abort,
    input wire logic [`AIS_OD_W-1:0] od_rdata,
    // Results
    input wire logic [`AIS_VAL_W-1:0] value_first,
    input wire logic [`AIS_VAL_W-1:0] value_second,
    input wire logic scale_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_count_rd;
        od_req && !od_write && od_subindex == 8'h00 && od_index[15:2] == 14'h0CC8;
    endsequence
    sequence s_answer;
        od_ack ^ od_abort;
    endsequence
    a_one_answer: assert property (od_req |=> s_answer)
        else $error("request not answered once");
    a_no_stray: assert property (!od_req |=> !od_ack && !od_abort)
        else $error("answer without request");
    a_count_read: assert property (s_count_rd |=> od_ack && od_rdata == 32'h0000_0002)
        else $error("count entry wrong");
    a_count_ro: assert property (od_req && od_write && od_subindex == 8'h00 |=> od_abort)
        else $error("count entry written");
    a_value_ro: assert property (od_req && od_write && od_index == 16'h3320 |=> od_abort)
        else $error("scaled value written");
    a_bad_entry: assert property (od_req && (od_subindex > 8'h02 || (od_subindex == 8'h02 && !SECOND_PRESENT))
        |=> od_abort)
        else $error("missing entry accepted");
    a_rdata_hold: assert property ($changed(od_rdata) |-> od_ack)
        else $error("read data moved without ack");
    a_value_upd: assert property ($changed(value_first) || $changed(value_second) |-> $past(scale_busy))
        else $error("value moved outside scaling");
    a_start_busy: assert property (adc_valid_first && !scale_busy |-> ##2 scale_busy)
        else $error("sample did not start scaling");
    a_busy_bound: assert property ($rose(scale_busy) |-> ##[2:150] !scale_busy)
        else $error("scaling never finished");
endmodule

bind ais_top ais_top_assertions #(.SECOND_PRESENT(SECOND_PRESENT)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .adc_valid_first(adc_valid_first), .od_req(od_req),
    .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex), .od_ack(od_ack),
    .od_abort(od_abort), .od_rdata(od_rdata), .value_first(value_first),
    .value_second(value_second), .scale_busy(scale_busy));

`default_nettype wire

//--- tb/tb_analog_input_scaling.sv
// Self-checking bench for the analog input scaling top.
// Assumes the converter model and the checker are compiled first.
`include "ais_cfg.svh"
`default_nettype none

module tb_analog_input_scaling;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic od_req = 1'b0;
    logic od_write = 1'b0;
    logic [15:0] od_index = 16'h0000;
    logic [7:0] od_subindex = 8'h00;
    logic [31:0] od_wdata = 32'h0000_0000;
    logic [`AIS_ADC_W-1:0] raw_a, raw_b;
    logic vld_a, vld_b, ack, abt, busy, ack2, abt2;
    logic [31:0] rdata, val_a, val_b, val_b2;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int off [2] = '{0, 0};
    int mul [2] = '{1, 1};
    int dvs [2] = '{1, 1};
    longint exp_v [2] = '{0, 0};

    ais_adc_model adc (.sys_clk(sys_clk), .adc_raw_first(raw_a), .adc_raw_second(raw_b),
        .adc_valid_first(vld_a), .adc_valid_second(vld_b));
    ais_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .adc_raw_first(raw_a), .adc_raw_second(raw_b),
        .adc_valid_first(vld_a), .adc_valid_second(vld_b), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(ack),
        .od_abort(abt), .od_rdata(rdata), .value_first(val_a), .value_second(val_b), .scale_busy(busy));
    // Variant without a second input shares every stimulus
    ais_top #(.SECOND_PRESENT(1'b0)) dut_one (.sys_clk(sys_clk), .rst_n(rst_n), .adc_raw_first(raw_a),
        .adc_raw_second(raw_b), .adc_valid_first(vld_a), .adc_valid_second(vld_b), .od_req(od_req),
        .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
        .od_ack(ack2), .od_abort(abt2), .od_rdata(), .value_first(), .value_second(val_b2), .scale_busy());

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic od(input bit w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
            input bit ok, input logic [31:0] want);
        bit ok2;
        ok2 = ok && s != 8'h02;
        @(posedge sys_clk);
        od_req <= 1'b1;
        od_write <= w;
        od_index <= i;
        od_subindex <= s;
        od_wdata <= d;
        @(posedge sys_clk);
        od_req <= 1'b0;
        #1;
        chk("answer", {30'h0, ack, abt}, {30'h0, ok, !ok});
        chk("answer one input", {30'h0, ack2, abt2}, {30'h0, ok2, !ok2});
        if (!w && ok) chk("read data", rdata, want);
    endtask

    task automatic set(input int ch, input logic signed [15:0] o, m, v);
        int p [3];
        p = '{o, m, v};
        off[ch] = o;
        mul[ch] = m;
        dvs[ch] = v;
        for (int k = 0; k < 3; k++) begin
            od(1'b1, 16'(16'h3321 + k), 8'(ch + 1), {16'h0000, 16'(p[k])}, 1'b1, 32'h0);
            od(1'b0, 16'(16'h3321 + k), 8'(ch + 1), 32'h0, 1'b1, {16'h0000, 16'(p[k])});
        end
    endtask

    task automatic go(input int ch, input logic [`AIS_ADC_W-1:0] r);
        adc.convert(ch[0], r);
        // A zero divisor leaves the last result standing
        if (dvs[ch] != 0) exp_v[ch] = (longint'(r) + off[ch]) * mul[ch] / dvs[ch];
    endtask

    task automatic settle(input string name);
        int idle;
        idle = 0;
        for (int k = 0; k < 400 && idle < 4; k++) begin
            @(posedge sys_clk);
            #1;
            idle = busy ? 0 : idle + 1;
        end
        chk("value first", val_a, exp_v[0][31:0]);
        chk("value second", val_b, exp_v[1][31:0]);
        chk("value absent input", val_b2, 32'h0);
        $display("test %s done", name);
    endtask

    // The result lands 39 edges after the edge that takes the sample
    task automatic timed(input logic [`AIS_ADC_W-1:0] r);
        int n;
        n = 0;
        go(0, r);
        repeat (2) @(posedge sys_clk);
        for (int k = 0; k < 60 && val_a !== exp_v[0][31:0]; k++) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n == 1) chk("busy at start", {31'h0, busy}, 32'h1);
        end
        chk("scaling latency", 32'(n), 32'h27);
        chk("busy at end", {31'h0, busy}, 32'h0);
    endtask

    initial begin
        void'($urandom(32'h1045));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int s = 0; s < 4; s++) begin
                od(1'b0, 16'(16'h3320 + i), 8'(s), 32'h0, s < 3, s == 0 ? 32'h2 : (i < 2 ? 32'h0 : 32'h1));
            end
        end
        od(1'b1, 16'h3320, 8'h01, 32'h1234, 1'b0, 32'h0);
        od(1'b1, 16'h3322, 8'h00, 32'h0005, 1'b0, 32'h0);
        $display("test presets done");
        go(0, 10'h2BC);
        go(1, 10'h3FF);
        settle("unity");
        set(0, 16'h7FFF, 16'h8000, 16'hFFFF);
        go(0, 10'h3FF);
        settle("full width");
        for (int n = 0; n < 8; n++) begin
            set(n % 2, 16'($urandom), 16'($urandom), 16'($urandom) | 16'h0001);
            go(n % 2, 10'($urandom));
            settle("random");
        end
        set(1, 16'h0005, 16'h0003, 16'h0000);
        go(1, 10'h100);
        settle("zero divisor");
        set(1, 16'hFFF0, 16'h0002, 16'hFFFD);
        go(0, 10'h011);
        go(0, 10'h222);
        go(1, 10'h333);
        settle("collapse");
        // Software unit conversions applied through the scaling settings
        set(0, 16'hFE00, 16'h4E20, 16'h03FF);
        set(1, 16'h0000, 16'h4E20, 16'h03FF);
        timed(10'h3FF);
        go(1, 10'h200);
        settle("units");
        chk("millivolts", val_a, 32'((1023 - 512) * 20000 / 1023));
        chk("microamps", val_b, 32'(512 * 20000 / 1023));
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("value after reset", val_a, 32'h0);
        od(1'b0, 16'h3322, 8'h02, 32'h0, 1'b1, 32'h1);
        $display("test second reset done");
        end_of_test();
    end
endmodule

`default_nettype wire
